// ==== src/core_cfg.svh ====
// Opcode, field and timing constants for the branch, bit and modify decoder.
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
`define RESET_PC 16'h0000
`define HI_BTB 4'h0
`define HI_BRANCH 4'h2
`define HI_DIR 4'h3
`define HI_INH_A 4'h4
`define HI_INH_X 4'h5
`define HI_IX1 4'h6
`define HI_IX 4'h7
`define OP_MUL 8'h42
`define OP_CLEAR_MASK 8'h9A
`define OP_SET_MASK 8'h9B
`define FN_NEG 4'h0
`define FN_COM 4'h3
`define FN_LSR 4'h4
`define FN_ROR 4'h6
`define FN_ASR 4'h7
`define FN_LSL 4'h8
`define FN_ROL 4'h9
`define FN_DEC 4'hA
`define FN_INC 4'hC
`define FN_TST 4'hD
`define FN_CLR 4'hF
`define CYC_BRANCH 4'h3
`define CYC_BTB 4'h5
`define CYC_RMW_INH 4'h3
`define CYC_RMW_MEM 4'h5
`define CYC_RMW_IX1 4'h6
`define CYC_TST_MEM 4'h4
`define CYC_TST_IX1 4'h5
`define CYC_MASK 4'h2
`define CYC_MUL 4'hB
`define CYC_BAD 4'h2
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`endif

// ==== src/core_pkg.sv ====
// Types shared by the decoder and the sequencer.
package core_pkg;
   typedef enum logic [2:0] {
      CL_BAD = 3'b000,
      CL_BRANCH = 3'b001,
      CL_BTB = 3'b010,
      CL_RMW = 3'b011,
      CL_MASK = 3'b100,
      CL_MUL = 3'b101
   } class_e;
   typedef enum logic [2:0] {
      MD_A = 3'b000,
      MD_X = 3'b001,
      MD_DIR = 3'b010,
      MD_IX = 3'b011,
      MD_IX1 = 3'b100
   } mode_e;
   typedef struct packed {
      logic [3:0] cnt;
      logic [15:0] pc;
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] dat;
      logic [7:0] acc;
      logic [7:0] idx;
      logic flag_h;
      logic flag_i;
      logic flag_n;
      logic flag_z;
      logic flag_c;
      logic [1:0] pin_sync;
      logic [15:0] pm_addr;
      logic [7:0] dm_addr;
      logic dm_rd;
      logic dm_wr;
      logic [7:0] dm_wdata;
      logic done;
      logic bad;
   } state_s;
endpackage : core_pkg

// ==== src/dec_if.sv ====
// Opcode in, decoded class, mode, function, length and cycle count out.
`timescale 1ns/1ps
interface dec_if;
   import core_pkg::*;
   logic [7:0] op;
   class_e cls;
   mode_e mode;
   logic [3:0] fn;
   logic [1:0] nbytes;
   logic [3:0] ncyc;
   modport dec (input op, output cls, mode, fn, nbytes, ncyc);
   modport user (output op, input cls, mode, fn, nbytes, ncyc);
endinterface : dec_if

// ==== src/op_decode.sv ====
// Combinational opcode decoder for the branch, bit and modify groups.
`timescale 1ns/1ps
`include "core_cfg.svh"
module op_decode
   import core_pkg::*;
(
   dec_if.dec d
);
   logic [3:0] hi;
   logic [3:0] lo;
   logic legal_fn;

   assign hi = d.op[7:4];
   assign lo = d.op[3:0];
   assign legal_fn = (lo == `FN_NEG) || (lo == `FN_COM) || (lo == `FN_LSR) ||
                     (lo == `FN_ROR) || (lo == `FN_ASR) || (lo == `FN_LSL) ||
                     (lo == `FN_ROL) || (lo == `FN_DEC) || (lo == `FN_INC) ||
                     (lo == `FN_TST) || (lo == `FN_CLR);

   always_comb begin
      d.cls = CL_BAD;
      d.mode = MD_A;
      d.fn = lo;
      d.nbytes = `LEN_ONE;
      d.ncyc = `CYC_BAD;
      if (hi == `HI_BRANCH) begin
         d.cls = CL_BRANCH;
         d.nbytes = `LEN_TWO;
         d.ncyc = `CYC_BRANCH;
      end else if (hi == `HI_BTB) begin
         d.cls = CL_BTB;
         d.mode = MD_DIR;
         d.nbytes = `LEN_THREE;
         d.ncyc = `CYC_BTB;
      end else if (d.op == `OP_MUL) begin
         d.cls = CL_MUL;
         d.ncyc = `CYC_MUL;
      end else if (d.op == `OP_SET_MASK || d.op == `OP_CLEAR_MASK) begin
         d.cls = CL_MASK;
         d.ncyc = `CYC_MASK;
      end else if (legal_fn && hi >= `HI_DIR && hi <= `HI_IX) begin
         d.cls = CL_RMW;
         case (hi)
            `HI_INH_A: begin
               d.mode = MD_A;
               d.ncyc = `CYC_RMW_INH;
            end
            `HI_INH_X: begin
               d.mode = MD_X;
               d.ncyc = `CYC_RMW_INH;
            end
            `HI_DIR: begin
               d.mode = MD_DIR;
               d.nbytes = `LEN_TWO;
               d.ncyc = (lo == `FN_TST) ? `CYC_TST_MEM : `CYC_RMW_MEM;
            end
            `HI_IX: begin
               d.mode = MD_IX;
               d.ncyc = (lo == `FN_TST) ? `CYC_TST_MEM : `CYC_RMW_MEM;
            end
            default: begin
               d.mode = MD_IX1;
               d.nbytes = `LEN_TWO;
               d.ncyc = (lo == `FN_TST) ? `CYC_TST_IX1 : `CYC_RMW_IX1;
            end
         endcase
      end
   end
endmodule : op_decode

// ==== src/core_seq.sv ====
// Instruction sequencer: fetch, operand access and execute with exact timing.
`timescale 1ns/1ps
`include "core_cfg.svh"
module core_seq
   import core_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // Program memory, data one cycle after the address
   output logic [15:0] PM_ADDR,
   input wire logic [7:0] PM_DATA,
   // Data memory, read data valid in the cycle the address is shown
   output logic [7:0] DM_ADDR,
   output logic DM_RD,
   output logic DM_WR,
   output logic [7:0] DM_WDATA,
   input wire logic [7:0] DM_RDATA,
   // External interrupt pin
   input wire logic INT_PIN,
   // Core state
   output logic [15:0] PC,
   output logic [7:0] ACC,
   output logic [7:0] IDX,
   output logic [4:0] CCR,
   output logic INSTR_DONE,
   output logic BAD_OPCODE
);
   state_s s_r;
   state_s s_nxt;
   dec_if dif ();

   logic [7:0] opnd;
   logic [7:0] res;
   logic carry_nxt;
   logic base;
   logic taken;
   logic tbit;
   logic [7:0] off;
   logic [15:0] prod;
   logic last;

   // During the opcode cycle the byte is decoded straight off the bus.
   assign dif.op = (s_r.cnt == 4'h1) ? PM_DATA : s_r.op;

   op_decode u_dec (
      .d(dif)
   );

   assign last = (s_r.cnt == dif.ncyc - 4'h1);
   assign prod = s_r.idx * s_r.acc;

   always_comb begin
      opnd = s_r.dm_rd ? DM_RDATA : s_r.dat;
      if (dif.mode == MD_A) begin
         opnd = s_r.acc;
      end else if (dif.mode == MD_X) begin
         opnd = s_r.idx;
      end
      res = opnd;
      carry_nxt = s_r.flag_c;
      case (dif.fn)
         `FN_NEG: begin
            res = 8'h00 - opnd;
            carry_nxt = (opnd != 8'h00);
         end
         `FN_COM: begin
            res = ~opnd;
            carry_nxt = 1'b1;
         end
         `FN_LSR: begin
            res = {1'b0, opnd[7:1]};
            carry_nxt = opnd[0];
         end
         `FN_ROR: begin
            res = {s_r.flag_c, opnd[7:1]};
            carry_nxt = opnd[0];
         end
         `FN_ASR: begin
            res = {opnd[7], opnd[7:1]};
            carry_nxt = opnd[0];
         end
         `FN_LSL: begin
            res = {opnd[6:0], 1'b0};
            carry_nxt = opnd[7];
         end
         `FN_ROL: begin
            res = {opnd[6:0], s_r.flag_c};
            carry_nxt = opnd[7];
         end
         `FN_DEC: res = opnd - 8'h01;
         `FN_INC: res = opnd + 8'h01;
         `FN_CLR: res = 8'h00;
         default: res = opnd;
      endcase
   end

   // Condition pairs share op[3:1]; op[0] picks the "true" side.
   always_comb begin
      case (s_r.op[3:1])
         3'h1: base = s_r.flag_c | s_r.flag_z;
         3'h2: base = s_r.flag_c;
         3'h3: base = s_r.flag_z;
         3'h4: base = s_r.flag_h;
         3'h5: base = s_r.flag_n;
         3'h6: base = s_r.flag_i;
         3'h7: base = s_r.pin_sync[1];
         default: base = 1'b0;
      endcase
      tbit = s_r.dat[s_r.op[3:1]];
      // A relative branch decides in its last cycle, while its offset byte
      // is still on the program bus; a bit branch has latched its offset.
      if (dif.cls == CL_BTB) begin
         taken = s_r.op[0] ? ~tbit : tbit;
         off = s_r.b2;
      end else begin
         taken = s_r.op[0] ? base : ~base;
         off = PM_DATA;
      end
   end

   always_comb begin
      s_nxt = s_r;
      // The pin is asynchronous; only the second stage feeds the branch
      // test, which costs two cycles of lag on a pin change.
      s_nxt.pin_sync = {s_r.pin_sync[0], INT_PIN};
      s_nxt.done = 1'b0;
      s_nxt.bad = 1'b0;
      s_nxt.dm_rd = 1'b0;
      s_nxt.dm_wr = 1'b0;
      s_nxt.cnt = s_r.cnt + 4'h1;
      s_nxt.pm_addr = s_r.pm_addr + 16'h0001;
      if (s_r.cnt == 4'h1) begin
         s_nxt.op = PM_DATA;
      end
      if (s_r.cnt == 4'h2) begin
         s_nxt.b1 = PM_DATA;
      end
      if (s_r.cnt == 4'h3) begin
         s_nxt.b2 = PM_DATA;
      end
      if (s_r.dm_rd) begin
         s_nxt.dat = DM_RDATA;
      end
      if (dif.cls == CL_RMW || dif.cls == CL_BTB) begin
         if (dif.mode == MD_IX && s_r.cnt == 4'h1) begin
            s_nxt.dm_addr = s_r.idx;
            s_nxt.dm_rd = 1'b1;
         end else if (dif.mode == MD_DIR && s_r.cnt == 4'h2) begin
            s_nxt.dm_addr = PM_DATA;
            s_nxt.dm_rd = 1'b1;
         end else if (dif.mode == MD_IX1 && s_r.cnt == 4'h2) begin
            s_nxt.dm_addr = s_r.idx + PM_DATA;
            s_nxt.dm_rd = 1'b1;
         end
      end
      if (last) begin
         s_nxt.cnt = 4'h0;
         s_nxt.done = 1'b1;
         // Every instruction, taken or not, ends at its fixed cycle.
         s_nxt.pc = s_r.pc + {14'h0000, dif.nbytes};
         case (dif.cls)
            CL_BRANCH: begin
               if (taken) begin
                  s_nxt.pc = s_r.pc + 16'h0002 + {{8{off[7]}}, off};
               end
            end
            CL_BTB: begin
               s_nxt.flag_c = tbit;
               if (taken) begin
                  s_nxt.pc = s_r.pc + 16'h0003 + {{8{off[7]}}, off};
               end
            end
            CL_RMW: begin
               s_nxt.flag_c = carry_nxt;
               s_nxt.flag_n = res[7];
               s_nxt.flag_z = (res == 8'h00);
               if (dif.fn != `FN_TST) begin
                  if (dif.mode == MD_A) begin
                     s_nxt.acc = res;
                  end else if (dif.mode == MD_X) begin
                     s_nxt.idx = res;
                  end else begin
                     s_nxt.dm_wr = 1'b1;
                     s_nxt.dm_wdata = res;
                  end
               end
            end
            // The opcode register only loads at the end of cycle 1, so a
            // two-cycle instruction takes its bit from the live decode input.
            CL_MASK: s_nxt.flag_i = dif.op[0];
            CL_MUL: begin
               s_nxt.idx = prod[15:8];
               s_nxt.acc = prod[7:0];
               s_nxt.flag_h = 1'b0;
               s_nxt.flag_c = 1'b0;
            end
            default: s_nxt.bad = 1'b1;
         endcase
         s_nxt.pm_addr = s_nxt.pc;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         s_r <= '0;
         s_r.pc <= `RESET_PC;
         s_r.pm_addr <= `RESET_PC;
         s_r.flag_i <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign PM_ADDR = s_r.pm_addr;
   assign DM_ADDR = s_r.dm_addr;
   assign DM_RD = s_r.dm_rd;
   assign DM_WR = s_r.dm_wr;
   assign DM_WDATA = s_r.dm_wdata;
   assign PC = s_r.pc;
   assign ACC = s_r.acc;
   assign IDX = s_r.idx;
   assign CCR = {s_r.flag_h, s_r.flag_i, s_r.flag_n, s_r.flag_z, s_r.flag_c};
   assign INSTR_DONE = s_r.done;
   assign BAD_OPCODE = s_r.bad;
endmodule : core_seq

// ==== bench/core_seq_assertions.sv ====
// Timing and strobe checks on the sequencer's ports.
`timescale 1ns/1ps
module core_seq_assertions (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // Observed ports
   input wire logic [7:0] PM_DATA,
   input wire logic DM_WR,
   input wire logic [15:0] PC,
   input wire logic [4:0] CCR,
   input wire logic INSTR_DONE,
   input wire logic BAD_OPCODE
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);
   // The opcode shows on PM_DATA one cycle after the previous instruction's INSTR_DONE pulse.
   property p_rst;
      disable iff (1'b0) SRST |=> PC == 16'h0000 && CCR == 5'h08;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_branch;
      INSTR_DONE ##1 PM_DATA[7:4] == 4'h2 |=> !INSTR_DONE ##1 INSTR_DONE;
   endproperty
   a_branch: assert property (p_branch) else $error("branch length");
   property p_btb;
      INSTR_DONE ##1 PM_DATA[7:4] == 4'h0 |=> !INSTR_DONE [*3] ##1 INSTR_DONE;
   endproperty
   a_btb: assert property (p_btb) else $error("bit branch length");
   property p_mask;
      INSTR_DONE ##1 PM_DATA[7:1] == 7'h4D |=> INSTR_DONE;
   endproperty
   a_mask: assert property (p_mask) else $error("mask op length");
   property p_sei;
      INSTR_DONE ##1 PM_DATA == 8'h9B |=> CCR[3];
   endproperty
   a_sei: assert property (p_sei) else $error("mask not set");
   property p_cli;
      INSTR_DONE ##1 PM_DATA == 8'h9A |=> !CCR[3];
   endproperty
   a_cli: assert property (p_cli) else $error("mask not cleared");
   property p_mul;
      INSTR_DONE ##1 PM_DATA == 8'h42 |-> ##10 INSTR_DONE;
   endproperty
   a_mul: assert property (p_mul) else $error("multiply length");
   property p_ix1;
      INSTR_DONE ##1 PM_DATA inside {8'h69, 8'h66}
         |=> !INSTR_DONE [*4] ##1 INSTR_DONE;
   endproperty
   a_ix1: assert property (p_ix1) else $error("offset form length");
   property p_tst;
      INSTR_DONE ##1 PM_DATA inside {8'h3D, 8'h7D, 8'h6D} |=> !DM_WR [*4];
   endproperty
   a_tst: assert property (p_tst) else $error("test wrote back");
   property p_wr;
      DM_WR |-> INSTR_DONE;
   endproperty
   a_wr: assert property (p_wr) else $error("write off the end");
   property p_gap;
      INSTR_DONE |=> !INSTR_DONE ##[1:10] INSTR_DONE;
   endproperty
   a_gap: assert property (p_gap) else $error("done spacing");
   property p_bad;
      BAD_OPCODE |-> INSTR_DONE;
   endproperty
   a_bad: assert property (p_bad) else $error("lone bad opcode flag");
   c_wr: cover property (DM_WR);
   c_bad: cover property (BAD_OPCODE);
   c_mul: cover property (INSTR_DONE ##1 PM_DATA == 8'h42);
endmodule : core_seq_assertions
bind core_seq core_seq_assertions u_core_seq_assertions (.CLK_SYS(CLK_SYS),
   .SRST(SRST), .PM_DATA(PM_DATA), .DM_WR(DM_WR), .PC(PC), .CCR(CCR),
   .INSTR_DONE(INSTR_DONE), .BAD_OPCODE(BAD_OPCODE));

// ==== bench/mem_model.sv ====
// Program and data memory standing opposite the sequencer.
`timescale 1ns/1ps
module mem_model (
   // Clock
   input wire logic CLK_SYS,
   // Program memory, only the low address byte is decoded
   input wire logic [15:0] PM_ADDR,
   output logic [7:0] PM_DATA,
   // Data memory
   input wire logic [7:0] DM_ADDR,
   input wire logic DM_RD,
   input wire logic DM_WR,
   input wire logic [7:0] DM_WDATA,
   output logic [7:0] DM_RDATA
);
   logic [7:0] pm [0:255];
   logic [7:0] dm [0:255];
   logic [7:0] tick = 8'h00;
   initial begin
      for (int i = 0; i < 256; i++) begin
         pm[i] = 8'h9D;
         dm[i] = 8'h00;
      end
   end
   always @(posedge CLK_SYS) begin
      PM_DATA <= pm[PM_ADDR[7:0]];
      tick <= tick + 8'h01;
      if (DM_WR) begin
         dm[DM_ADDR] <= DM_WDATA;
      end
   end
   // Outside a read the bus shows a moving pattern so a stale byte is caught.
   assign DM_RDATA = DM_RD ? dm[DM_ADDR] : tick;
endmodule : mem_model

// ==== bench/cpu_branch_bit_rmw_decode_bench.sv ====
// Self-checking bench running two short programs through the sequencer.
`timescale 1ns/1ps
module cpu_branch_bit_rmw_decode_bench;
   logic CLK_SYS = 1'b0;
   logic SRST = 1'b1;
   logic INT_PIN = 1'b0;
   logic [15:0] PM_ADDR, PC;
   logic [7:0] PM_DATA, DM_ADDR, DM_WDATA, DM_RDATA, ACC, IDX;
   logic DM_RD, DM_WR, INSTR_DONE, BAD_OPCODE;
   logic [4:0] CCR;
   int miscompares = 0;
   int n_tests = 0;
   logic [7:0] prog [0:52] = '{8'h9A, 8'h2C, 8'h02, 8'h9D, 8'h9D, 8'h2D,
      8'h7F, 8'h9B, 8'h01, 8'h40, 8'h03, 8'h49, 8'h25, 8'hFE, 8'h24, 8'h02,
      8'h9D, 8'h9D, 8'h39, 8'h41, 8'h3D, 8'h41, 8'h2E, 8'h02, 8'h9D, 8'h9D,
      8'h42, 8'h22, 8'h10, 8'h28, 8'h02, 8'h9D, 8'h9D, 8'h2F, 8'h02, 8'h23,
      8'h02, 8'h9D, 8'h9D, 8'h00, 8'h40, 8'h02, 8'h9D, 8'h9D, 8'h46, 8'h4D,
      8'h66, 8'h05, 8'h7D, 8'h9D, 8'h20, 8'hFE, 8'h9D};
   // Address reached at each completion, and the cycles that step took.
   logic [7:0] xpc [0:22] = '{8'h01, 8'h05, 8'h07, 8'h08, 8'h0B, 8'h0C,
      8'h0E, 8'h12, 8'h14, 8'h16, 8'h1A, 8'h1B, 8'h1D, 8'h21, 8'h23, 8'h27,
      8'h2C, 8'h2D, 8'h2E, 8'h30, 8'h31, 8'h32, 8'h32};
   logic [7:0] xcyc [0:22] = '{8'h02, 8'h03, 8'h03, 8'h02, 8'h05, 8'h03,
      8'h03, 8'h03, 8'h05, 8'h04, 8'h03, 8'h0B, 8'h03, 8'h03, 8'h03, 8'h03,
      8'h05, 8'h03, 8'h03, 8'h06, 8'h04, 8'h02, 8'h03};
   // Second program: mask flips right after opcodes of the other parity.
   logic [7:0] prog2 [0:17] = '{8'h9B, 8'h2D, 8'h02, 8'h9D, 8'h9D, 8'h9A,
      8'h2F, 8'h02, 8'h9D, 8'h9D, 8'h2E, 8'h7F, 8'h2C, 8'h02, 8'h9D, 8'h9D,
      8'h20, 8'hFE};
   logic [7:0] xpc2 [0:5] = '{8'h01, 8'h05, 8'h06, 8'h0A, 8'h0C, 8'h10};
   logic [7:0] xcyc2 [0:5] = '{8'h02, 8'h03, 8'h02, 8'h03, 8'h03, 8'h03};
   always #5 CLK_SYS = ~CLK_SYS;
   core_seq u_core_seq (.CLK_SYS(CLK_SYS), .SRST(SRST), .PM_ADDR(PM_ADDR),
      .PM_DATA(PM_DATA), .DM_ADDR(DM_ADDR), .DM_RD(DM_RD), .DM_WR(DM_WR),
      .DM_WDATA(DM_WDATA), .DM_RDATA(DM_RDATA), .INT_PIN(INT_PIN), .PC(PC),
      .ACC(ACC), .IDX(IDX), .CCR(CCR), .INSTR_DONE(INSTR_DONE),
      .BAD_OPCODE(BAD_OPCODE));
   mem_model u_mem_model (.CLK_SYS(CLK_SYS), .PM_ADDR(PM_ADDR),
      .PM_DATA(PM_DATA), .DM_ADDR(DM_ADDR), .DM_RD(DM_RD), .DM_WR(DM_WR),
      .DM_WDATA(DM_WDATA), .DM_RDATA(DM_RDATA));
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task test_done;
      if (miscompares == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   // Loading waits a step so the model's own fill has landed first.
   task load_prog;
      #1;
      for (int i = 0; i < 53; i++) begin
         u_mem_model.pm[i] = prog[i];
      end
      u_mem_model.dm[8'h40] = 8'h01;
      u_mem_model.dm[8'h41] = 8'h80;
      u_mem_model.dm[8'h05] = 8'h02;
   endtask : load_prog
   task check_reset;
      repeat (5) @(posedge CLK_SYS);
      #1;
      chk(PC, 16'h0000);
      chk({ACC, 3'h0, CCR}, 16'h0008);
      @(posedge CLK_SYS);
      SRST <= 1'b0;
   endtask : check_reset
   // Running out of the cycle limit counts as a mismatch here.
   task wait_done(output int n);
      n = 0;
      do begin
         @(posedge CLK_SYS);
         #1;
         n++;
      end while (INSTR_DONE !== 1'b1 && n < 20);
      chk(16'(INSTR_DONE), 16'h0001);
   endtask : wait_done
   task run_trace;
      int n;
      for (int i = 0; i < 23; i++) begin
         wait_done(n);
         chk(PC, {8'h00, xpc[i]});
         chk(16'(BAD_OPCODE), 16'(i == 21));
         if (i > 0) begin
            chk(16'(n), {8'h00, xcyc[i]});
         end
      end
   endtask : run_trace
   task check_final;
      chk({ACC, IDX}, 16'h8000);
      chk(16'(CCR), 16'h000A);
      chk(16'(u_mem_model.dm[8'h41]), 16'h0000);
      chk(16'(u_mem_model.dm[8'h05]), 16'h0001);
   endtask : check_final
   // A mid-run reset starts the second program with the pin held high.
   task run_mask_pin;
      int n;
      @(posedge CLK_SYS);
      SRST <= 1'b1;
      INT_PIN <= 1'b1;
      @(posedge CLK_SYS);
      #1;
      for (int i = 0; i < 18; i++) begin
         u_mem_model.pm[i] = prog2[i];
      end
      repeat (4) @(posedge CLK_SYS);
      SRST <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         wait_done(n);
         chk(PC, {8'h00, xpc2[i]});
         chk(16'(n), {8'h00, xcyc2[i]});
      end
      chk(16'(CCR), 16'h0000);
   endtask : run_mask_pin
   initial begin
      load_prog();
      check_reset();
      run_trace();
      check_final();
      run_mask_pin();
      test_done();
   end
   initial begin
      #20000;
      miscompares++;
      test_done();
   end
endmodule : cpu_branch_bit_rmw_decode_bench
